// ### design/pwd_cpu_end.sv
// CPU end: paged call and return sequencing plus a plain user-side bus port.
`timescale 1ns/1ps
`default_nettype none
module pwd_cpu_end (
	input wire logic ref_clk,
	input wire logic nrst,
	pwd_bus_if.cpu bus,
	input wire logic [15:0] u_addr,
	input wire logic [15:0] u_wdata,
	input wire logic u_wr,
	input wire logic u_rd,
	input wire logic u_byte,
	input wire logic call_req,
	input wire logic call_indirect,
	input wire logic [5:0] call_page,
	input wire logic [15:0] call_target,
	input wire logic [15:0] call_ret_addr,
	input wire logic rtc_req,
	input wire logic [15:0] sp_in,
	output logic [15:0] u_rdata,
	output logic busy,
	output logic irq_block,
	output logic [15:0] pc_out
);
	typedef enum logic [3:0] {
		S_IDLE, S_IND_PG, S_IND_PGW, S_IND_AD, S_IND_ADW, S_LOAD, S_PUSH_RA, S_PUSH_PG,
		S_JUMP, S_PULL_PG, S_PULL_PGW, S_PULL_RA, S_PULL_RAW, S_RESTORE
	} pwd_cpu_st_e;
	pwd_cpu_st_e st_r;
	logic [5:0] old_page_r;
	logic [5:0] new_page_r;
	logic [15:0] target_r;
	logic [15:0] ret_r;
	logic [15:0] sp_r;
	logic [15:0] pc_r;

	// The sequence owns the bus; user strobes are dropped outside S_IDLE and while call_req or rtc_req is raised.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= S_IDLE;
			old_page_r <= 6'h00;
			new_page_r <= 6'h00;
			target_r <= 16'h0000;
			ret_r <= 16'h0000;
			sp_r <= 16'h0000;
			pc_r <= 16'h0000;
			busy <= 1'b0;
			irq_block <= 1'b0;
			u_rdata <= 16'h0000;
			pc_out <= 16'h0000;
		end else begin
			u_rdata <= bus.rdata;
			pc_out <= pc_r;
			irq_block <= (st_r != S_IDLE) || call_req || rtc_req;
			busy <= (st_r != S_IDLE) || call_req || rtc_req;
			case (st_r)
				S_IDLE: begin
					sp_r <= sp_in;
					if (call_req) begin
						ret_r <= call_ret_addr;
						target_r <= call_target;
						new_page_r <= call_page;
						st_r <= call_indirect ? S_IND_PG : S_LOAD;
					end else if (rtc_req) begin
						st_r <= S_PULL_PG;
					end
				end
				S_IND_PG: st_r <= S_IND_PGW;
				S_IND_PGW: begin
					new_page_r <= bus.rdata[5:0];
					st_r <= S_IND_AD;
				end
				S_IND_AD: st_r <= S_IND_ADW;
				S_IND_ADW: begin
					target_r <= bus.rdata;
					st_r <= S_LOAD;
				end
				S_LOAD: begin
					old_page_r <= bus.page_value;
					st_r <= S_PUSH_RA;
				end
				S_PUSH_RA: begin
					sp_r <= sp_r - 16'h0002;
					st_r <= S_PUSH_PG;
				end
				S_PUSH_PG: begin
					sp_r <= sp_r - 16'h0001;
					st_r <= S_JUMP;
				end
				S_JUMP: begin
					pc_r <= target_r;
					st_r <= S_IDLE;
				end
				S_PULL_PG: st_r <= S_PULL_PGW;
				S_PULL_PGW: begin
					old_page_r <= bus.rdata[5:0];
					sp_r <= sp_r + 16'h0001;
					st_r <= S_PULL_RA;
				end
				S_PULL_RA: st_r <= S_PULL_RAW;
				S_PULL_RAW: begin
					pc_r <= bus.rdata;
					sp_r <= sp_r + 16'h0002;
					st_r <= S_RESTORE;
				end
				S_RESTORE: st_r <= S_IDLE;
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// Call target pointer sits in call_target; page byte at the pointer, address word at the pointer plus one.
	always_comb begin
		bus.addr = u_addr;
		bus.wdata = u_wdata;
		bus.wr = u_wr && (st_r == S_IDLE) && !call_req && !rtc_req;
		bus.rd = u_rd && (st_r == S_IDLE) && !call_req && !rtc_req;
		bus.byte_acc = u_byte;
		bus.page_load = 1'b0;
		bus.page_load_val = new_page_r;
		case (st_r)
			S_IND_PG: begin
				bus.addr = target_r;
				bus.rd = 1'b1;
				bus.byte_acc = 1'b1;
			end
			S_IND_AD: begin
				bus.addr = target_r + 16'h0001;
				bus.rd = 1'b1;
				bus.byte_acc = 1'b0;
			end
			S_LOAD: bus.page_load = 1'b1;
			S_PUSH_RA: begin
				bus.addr = sp_r - 16'h0002;
				bus.wdata = ret_r;
				bus.wr = 1'b1;
				bus.byte_acc = 1'b0;
			end
			S_PUSH_PG: begin
				bus.addr = sp_r - 16'h0003;
				bus.wdata = {10'h000, old_page_r};
				bus.wr = 1'b1;
				bus.byte_acc = 1'b1;
			end
			S_PULL_PG: begin
				bus.addr = sp_r;
				bus.rd = 1'b1;
				bus.byte_acc = 1'b1;
			end
			S_PULL_RA: begin
				bus.addr = sp_r;
				bus.rd = 1'b1;
				bus.byte_acc = 1'b0;
			end
			S_RESTORE: begin
				bus.page_load = 1'b1;
				bus.page_load_val = old_page_r;
			end
			default: begin
			end
		endcase
	end
endmodule
`default_nettype wire

// ### design/pwd_pkg.sv
// Shared constants and types for the page window address decoder and its CPU end.
package pwd_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int PIX_W = 6;
	localparam int XADDR_W = 6;
	localparam logic [15:0] WIN_LO = 16'h8000;
	localparam logic [15:0] WIN_HI = 16'hbfff;
	localparam logic [15:0] UNPAGED_LO = 16'hc000;
	localparam logic [15:0] BANK1_LO = 16'h4000;
	localparam logic [5:0] XA_BANK0 = 6'h3d;
	localparam logic [5:0] XA_BANK1 = 6'h3e;
	localparam logic [5:0] XA_BANK3 = 6'h3f;
	localparam logic [5:0] EXT_LIMIT_00 = 6'h37;
	localparam logic [5:0] EXT_LIMIT_01 = 6'h2f;
	localparam logic [5:0] EXT_LIMIT_10 = 6'h1f;
	localparam logic [5:0] PAGE_RESET = 6'h00;
	// Register block layout, 1K block at default base 0.
	localparam logic [15:0] REG_BASE = 16'h0000;
	localparam logic [15:0] REG_SIZE = 16'h0400;
	localparam logic [15:0] EXP_REGS = 16'h0010;
	localparam logic [15:0] PORT_A_DATA_OFS = 16'h0000;
	localparam logic [15:0] PORT_B_DATA_OFS = 16'h0001;
	localparam logic [15:0] PORT_A_DIRECTION_OFS = 16'h0002;
	localparam logic [15:0] PORT_B_DIRECTION_OFS = 16'h0003;
	localparam logic [15:0] PORT_E_DATA_OFS = 16'h0008;
	localparam logic [15:0] PORT_E_DIRECTION_OFS = 16'h0009;
	localparam logic [15:0] PAGE_OFS = 16'h0030;
	localparam logic [15:0] PORTK_OFS = 16'h0032;
	localparam logic [15:0] DDRK_OFS = 16'h0033;
	localparam logic [15:0] IMPL_LIMIT = 16'h0040;
	localparam logic [15:0] DBG_LO = 16'hff00;
	localparam logic [15:0] RAM_BASE = 16'h0800;
	localparam logic [15:0] RAM_SIZE = 16'h0800;
	localparam logic [15:0] EE_BASE = 16'h1000;
	localparam logic [15:0] EE_SIZE = 16'h0800;
	localparam int NSEL = 6;
	typedef enum logic [2:0] {
		PWD_SEL_DBG, PWD_SEL_REG, PWD_SEL_RAM, PWD_SEL_EE, PWD_SEL_ROM, PWD_SEL_EXT
	} pwd_sel_e;
	typedef enum logic [1:0] {
		PWD_MODE_SINGLE, PWD_MODE_EXPANDED, PWD_MODE_EMULATION, PWD_MODE_PERIPH
	} pwd_mode_e;
endpackage

// ### design/pwd_bus_if.sv
// Core bus between the CPU end and the page window address decoder.
`timescale 1ns/1ps
`default_nettype none
interface pwd_bus_if;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic byte_acc;
	logic [15:0] rdata;
	logic page_load;
	logic [5:0] page_load_val;
	logic [5:0] page_value;
	modport dec (input addr, wdata, wr, rd, byte_acc, page_load, page_load_val,
		output rdata, page_value);
	modport cpu (output addr, wdata, wr, rd, byte_acc, page_load, page_load_val,
		input rdata, page_value);
endinterface
`default_nettype wire

// ### design/pwd_sel_prio.sv
// Priority encoder turning per-block hit flags into one one-hot select, all zero when no block hits.
`timescale 1ns/1ps
`default_nettype none
module pwd_sel_prio (
	input wire logic [pwd_pkg::NSEL-1:0] hit,
	output logic [pwd_pkg::NSEL-1:0] sel
);
	// Bit 0 is the highest priority; each bit yields to every lower index.
	genvar i;
	generate
		for (i = 0; i < pwd_pkg::NSEL; i++) begin : g_pri
			if (i == 0) begin : g_top
				assign sel[i] = hit[i];
			end else begin : g_rest
				assign sel[i] = hit[i] & ~(|hit[i-1:0]);
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### design/pwd_decoder.sv
// Page window address decoder: block selects, external selects, page register, data steering.
`timescale 1ns/1ps
`default_nettype none
module pwd_decoder (
	input wire logic ref_clk,
	input wire logic nrst,
	pwd_bus_if.dec bus,
	input wire logic [1:0] mode,
	input wire logic port_e_data_expand_enable,
	input wire logic portk_expand_enable,
	input wire logic [1:0] paging_partition_switches,
	input wire logic page_write_allowed,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] ram_rdata,
	input wire logic [15:0] ee_rdata,
	input wire logic [15:0] rom_rdata,
	input wire logic [15:0] ext_rdata,
	input wire logic [15:0] dbg_rdata,
	output logic [5:0] block_sel,
	output logic window_internal,
	output logic [5:0] extended_address_hi,
	output logic emulation_select_n,
	output logic external_select_n,
	output logic portk_pins_owned,
	output logic [15:0] core_addr,
	output logic [15:0] core_wdata,
	output logic core_wr,
	output logic core_rd
);
	logic [5:0] program_page_index_r;
	logic [15:0] ofs;
	logic expanded;
	logic emul;
	logic periph;
	logic in_reg;
	logic reg_removed;
	logic reg_impl;
	logic in_win;
	logic win_ext;
	logic [5:0] hit;
	logic [5:0] sel;
	logic [5:0] page_eff;
	logic [2:0] rd_src_r;
	logic swap_r;
	logic [15:0] rmux;

	assign expanded = (mode == pwd_pkg::PWD_MODE_EXPANDED) || (mode == pwd_pkg::PWD_MODE_EMULATION);
	assign emul = (mode == pwd_pkg::PWD_MODE_EMULATION);
	assign periph = (mode == pwd_pkg::PWD_MODE_PERIPH);
	assign ofs = bus.addr - pwd_pkg::REG_BASE;
	assign in_reg = (bus.addr >= pwd_pkg::REG_BASE) && (ofs < pwd_pkg::REG_SIZE);
	assign reg_impl = ofs < pwd_pkg::IMPL_LIMIT;

	// Registers handed to the external bus leave the internal map.
	always_comb begin
		reg_removed = 1'b0;
		if (expanded && (ofs == pwd_pkg::PORT_A_DATA_OFS || ofs == pwd_pkg::PORT_B_DATA_OFS ||
			ofs == pwd_pkg::PORT_A_DIRECTION_OFS || ofs == pwd_pkg::PORT_B_DIRECTION_OFS)) begin
			reg_removed = 1'b1;
		end
		if (expanded && port_e_data_expand_enable &&
			(ofs == pwd_pkg::PORT_E_DATA_OFS || ofs == pwd_pkg::PORT_E_DIRECTION_OFS)) begin
			reg_removed = 1'b1;
		end
		if (periph && ofs < pwd_pkg::EXP_REGS) begin
			reg_removed = 1'b1;
		end
		if (emul && portk_expand_enable &&
			(ofs == pwd_pkg::PORTK_OFS || ofs == pwd_pkg::DDRK_OFS)) begin
			reg_removed = 1'b1;
		end
	end

	// A page loaded by an instruction is visible in the same cycle.
	assign page_eff = bus.page_load ? bus.page_load_val : program_page_index_r;
	assign in_win = (bus.addr >= pwd_pkg::WIN_LO) && (bus.addr <= pwd_pkg::WIN_HI);

	always_comb begin
		case (paging_partition_switches)
			2'b00: win_ext = page_eff <= pwd_pkg::EXT_LIMIT_00;
			2'b01: win_ext = page_eff <= pwd_pkg::EXT_LIMIT_01;
			2'b10: win_ext = page_eff <= pwd_pkg::EXT_LIMIT_10;
			default: win_ext = 1'b0;
		endcase
	end

	// Window pages at or below the partition limit fall through to external space.
	assign window_internal = in_win && !win_ext;
	assign hit[pwd_pkg::PWD_SEL_DBG] = bus.addr >= pwd_pkg::DBG_LO;
	assign hit[pwd_pkg::PWD_SEL_REG] = in_reg && !reg_removed;
	assign hit[pwd_pkg::PWD_SEL_RAM] = (bus.addr >= pwd_pkg::RAM_BASE) &&
		((bus.addr - pwd_pkg::RAM_BASE) < pwd_pkg::RAM_SIZE);
	assign hit[pwd_pkg::PWD_SEL_EE] = (bus.addr >= pwd_pkg::EE_BASE) &&
		((bus.addr - pwd_pkg::EE_BASE) < pwd_pkg::EE_SIZE);
	assign hit[pwd_pkg::PWD_SEL_ROM] = (in_win && !win_ext) || (bus.addr >= pwd_pkg::UNPAGED_LO);
	// Registers handed to the expansion bus in expanded or emulation mode are decoded as external accesses.
	assign hit[pwd_pkg::PWD_SEL_EXT] = expanded && (!in_reg || reg_removed);

	pwd_sel_prio u_prio (
		.hit(hit),
		.sel(sel)
	);

	assign block_sel = sel;
	assign emulation_select_n = !(portk_expand_enable && emul && sel[pwd_pkg::PWD_SEL_ROM]);
	// Removed or unimplemented register locations never raise the external select.
	assign external_select_n = !(portk_expand_enable && emulation_select_n &&
		sel[pwd_pkg::PWD_SEL_EXT] && !in_reg);
	assign portk_pins_owned = portk_expand_enable;

	always_comb begin
		if (!(expanded && portk_expand_enable)) begin
			extended_address_hi = pwd_pkg::XA_BANK3;
		end else if (in_win) begin
			extended_address_hi = page_eff;
		end else if (bus.addr < pwd_pkg::BANK1_LO) begin
			extended_address_hi = pwd_pkg::XA_BANK0;
		end else if (bus.addr < pwd_pkg::WIN_LO) begin
			extended_address_hi = pwd_pkg::XA_BANK1;
		end else begin
			extended_address_hi = pwd_pkg::XA_BANK3;
		end
	end

	// Instruction loads take precedence over a coincident bus write.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			program_page_index_r <= pwd_pkg::PAGE_RESET;
		end else if (bus.page_load) begin
			program_page_index_r <= bus.page_load_val;
		end else if (bus.wr && page_write_allowed && in_reg && ofs == pwd_pkg::PAGE_OFS) begin
			program_page_index_r <= bus.wdata[5:0];
		end
	end
	assign bus.page_value = program_page_index_r;

	// Read source and lane swap are captured so data return in the next cycle.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_src_r <= 3'h5;
			swap_r <= 1'b0;
		end else if (bus.rd) begin
			rd_src_r <= (in_reg && ofs == pwd_pkg::PAGE_OFS) ? 3'h6 :
				((sel == 6'h00) ? 3'h7 : 3'(pwd_pkg::PWD_SEL_DBG));
			for (int k = 0; k < pwd_pkg::NSEL; k++) begin
				if (sel[k]) begin
					rd_src_r <= (in_reg && ofs == pwd_pkg::PAGE_OFS) ? 3'h6 : 3'(k);
				end
			end
			swap_r <= bus.byte_acc && bus.addr[0];
		end
	end

	always_comb begin
		case (rd_src_r)
			3'h0: rmux = dbg_rdata;
			3'h1: rmux = reg_rdata;
			3'h2: rmux = ram_rdata;
			3'h3: rmux = ee_rdata;
			3'h4: rmux = rom_rdata;
			3'h5: rmux = ext_rdata;
			3'h6: rmux = {10'h000, program_page_index_r};
			default: rmux = 16'h0000;
		endcase
	end
	assign bus.rdata = swap_r ? {rmux[7:0], rmux[15:8]} : rmux;

	assign core_addr = bus.addr;
	assign core_wdata = (bus.byte_acc && bus.addr[0]) ?
		{bus.wdata[7:0], bus.wdata[7:0]} : bus.wdata;
	assign core_wr = bus.wr;
	assign core_rd = bus.rd;
endmodule
`default_nettype wire

// ### verif/pwd_chk.sv
// Concurrent checks on the core bus and the decoder's select outputs.
`timescale 1ns/1ps
`default_nettype none
module pwd_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic page_load,
	input wire logic [5:0] page_load_val,
	input wire logic [5:0] page_value,
	input wire logic [1:0] mode,
	input wire logic portk_expand_enable,
	input wire logic [1:0] paging_partition_switches,
	input wire logic page_write_allowed,
	input wire logic [5:0] block_sel,
	input wire logic window_internal,
	input wire logic [5:0] extended_address_hi,
	input wire logic emulation_select_n,
	input wire logic external_select_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic [5:0] lim;
	logic [5:0] wlo;
	logic win;
	logic xa_on;
	logic pg_hit;
	assign lim = (paging_partition_switches == 2'h0) ? pwd_pkg::EXT_LIMIT_00 :
		(paging_partition_switches == 2'h1) ? pwd_pkg::EXT_LIMIT_01 : pwd_pkg::EXT_LIMIT_10;
	assign wlo = wdata[5:0];
	assign win = addr >= pwd_pkg::WIN_LO && addr <= pwd_pkg::WIN_HI;
	assign xa_on = portk_expand_enable && (mode == 2'h1 || mode == 2'h2);
	assign pg_hit = wr && addr == pwd_pkg::PAGE_OFS;
	AST_ONE_SEL: assert property ($onehot0(block_sel))
		else $error("more than one block select active");
	AST_DBG_TOP: assert property (addr >= pwd_pkg::DBG_LO |-> block_sel == 6'h01)
		else $error("debug space not given top priority");
	AST_PAGE_WR: assert property (pg_hit && page_write_allowed && !page_load
		|=> page_value == $past(wlo))
		else $error("bus page write not effective one cycle later");
	AST_PAGE_HOLD: assert property (!pg_hit && !page_load |=> $stable(page_value))
		else $error("page value moved without a write");
	AST_PAGE_LOAD: assert property (page_load |=> page_value == $past(page_load_val))
		else $error("instruction page load lost");
	AST_WIN_XA: assert property (xa_on && win && !page_load
		|-> extended_address_hi == page_value)
		else $error("extended address not page in window");
	AST_TOP_XA: assert property (xa_on && addr >= pwd_pkg::UNPAGED_LO
		|-> extended_address_hi == pwd_pkg::XA_BANK3)
		else $error("extended address wrong in unpaged top block");
	AST_WIN_CLASS: assert property (win && !page_load
		|-> window_internal == (paging_partition_switches == 2'h3 || page_value > lim))
		else $error("window access misclassified");
	AST_ECS_XCS: assert property (!emulation_select_n |-> external_select_n)
		else $error("both external selects active");
	AST_GPIO: assert property (!portk_expand_enable
		|-> emulation_select_n && external_select_n)
		else $error("select pins driven while port K expansion off");
	AST_AB_QUIET: assert property (addr <= pwd_pkg::PORT_B_DIRECTION_OFS |-> external_select_n)
		else $error("external select active for removed port register");
endmodule
`default_nettype wire

// ### verif/tb_page_window_address_decoder.sv
// Self-checking bench: CPU end and decoder joined over the core bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module tb_page_window_address_decoder;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] mode = 2'h0;
	logic pe_en = 1'b0;
	logic pk_en = 1'b0;
	logic [1:0] sw = 2'h0;
	logic pw_ok = 1'b1;
	logic [15:0] src [6] = '{16'hbbcc, 16'h1122, 16'h3344, 16'h5566, 16'h7788, 16'h99aa};
	logic [15:0] u_addr = 16'h0, u_wdata = 16'h0, call_target = 16'h0, ret_a = 16'h0;
	logic [15:0] sp = 16'h0c00, u_rdata, pc_out, dat_s;
	logic u_wr = 1'b0, u_rd = 1'b0, u_byte = 1'b0, call_req = 1'b0, rtc_req = 1'b0;
	logic busy, irq_block, wi, ecs_n, xcs_n, wi_s, ecs_s, xcs_s;
	logic [5:0] call_page = 6'h0, blk_sel, xa, sel_s, xa_s, pg;
	logic [5:0] lims [3] = '{pwd_pkg::EXT_LIMIT_00, pwd_pkg::EXT_LIMIT_01, pwd_pkg::EXT_LIMIT_10};
	logic [15:0] xad [5] = '{16'h0000, 16'h0008, 16'h2000, 16'h4000, 16'h0800};
	logic [5:0] xsel [5] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h04};
	logic [4:0] xcs_e = 5'b10011;
	logic [5:0] xa_e [5] = '{6'h3d, 6'h3d, 6'h3d, 6'h3e, 6'h3d};
	int error_cnt = 0;
	int total_checks = 0;
	pwd_bus_if bif();
	pwd_decoder i_pwd_decoder (.ref_clk(ref_clk), .nrst(nrst), .bus(bif), .mode(mode),
		.port_e_data_expand_enable(pe_en), .portk_expand_enable(pk_en),
		.paging_partition_switches(sw), .page_write_allowed(pw_ok), .reg_rdata(src[1]),
		.ram_rdata(src[2]), .ee_rdata(src[3]), .rom_rdata(src[4]), .ext_rdata(src[5]),
		.dbg_rdata(src[0]), .block_sel(blk_sel), .window_internal(wi),
		.extended_address_hi(xa), .emulation_select_n(ecs_n), .external_select_n(xcs_n),
		.portk_pins_owned(), .core_addr(), .core_wdata(), .core_wr(), .core_rd());
	pwd_cpu_end i_pwd_cpu_end (.ref_clk(ref_clk), .nrst(nrst), .bus(bif), .u_addr(u_addr),
		.u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_byte(u_byte), .call_req(call_req),
		.call_indirect(1'b0), .call_page(call_page), .call_target(call_target),
		.call_ret_addr(ret_a), .rtc_req(rtc_req), .sp_in(sp), .u_rdata(u_rdata),
		.busy(busy), .irq_block(irq_block), .pc_out(pc_out));
	pwd_chk i_pwd_chk (.ref_clk(ref_clk), .nrst(nrst), .addr(bif.addr), .wdata(bif.wdata),
		.wr(bif.wr), .page_load(bif.page_load), .page_load_val(bif.page_load_val),
		.page_value(bif.page_value), .mode(mode), .portk_expand_enable(pk_en),
		.paging_partition_switches(sw), .page_write_allowed(pw_ok), .block_sel(blk_sel),
		.window_internal(wi), .extended_address_hi(xa), .emulation_select_n(ecs_n),
		.external_select_n(xcs_n));
	always #12.5 ref_clk = ~ref_clk;
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Selects are captured at the edge where the core bus read is sampled, data just after.
	task automatic rd(input logic [15:0] a, input logic b);
		{sel_s, xcs_s, ecs_s, wi_s, xa_s, dat_s} = 'x;
		u_addr <= a;
		u_byte <= b;
		u_rd <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			u_rd <= 1'b0;
			if (bif.rd === 1'b1) begin
				{sel_s, xcs_s, ecs_s, wi_s, xa_s} = {blk_sel, xcs_n, ecs_n, wi, xa};
				#1 dat_s = bif.rdata;
				break;
			end
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		u_addr <= a;
		u_wdata <= d;
		u_wr <= 1'b1;
		@(posedge ref_clk);
		u_wr <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("page reset", pwd_pkg::PAGE_RESET, bif.page_value)
		wr(16'h0030, 16'h2525);
		`CHK("page write", 6'h25, bif.page_value)
		pw_ok <= 1'b0;
		wr(16'h0030, 16'h0707);
		`CHK("page refused", 6'h25, bif.page_value)
		pw_ok <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(xad[i] & 16'h0000 | {16{1'b0}} | (i == 0 ? 16'hff00 : i == 1 ? 16'h0000 :
				i == 2 ? 16'h0800 : i == 3 ? 16'h1000 : 16'hc000), 1'b0);
			`CHK("prio sel", 6'h01 << i, sel_s)
			`CHK("read mux", src[i], dat_s)
		end
		rd(16'h0801, 1'b1);
		`CHK("byte swap", {src[2][7:0], src[2][15:8]}, dat_s)
		mode <= 2'h1;
		pe_en <= 1'b1;
		pk_en <= 1'b1;
		src[5] <= 16'h0ff0;
		for (int i = 0; i < 5; i++) begin
			rd(xad[i], 1'b0);
			`CHK("exp sel", xsel[i], sel_s)
			`CHK("exp xcs", xcs_e[i], xcs_s)
			`CHK("exp xa", xa_e[i], xa_s)
		end
		rd(16'h2000, 1'b0);
		`CHK("ext data", 16'h0ff0, dat_s)
		rd(16'h0050, 1'b0);
		`CHK("unimpl xcs", 1'b1, xcs_s)
		for (int s = 0; s < 4; s++) begin
			sw <= s[1:0];
			for (int k = 0; k < 2; k++) begin
				pg = (s == 3) ? 6'h00 : lims[s] + k[5:0];
				wr(16'h0030, {2'b00, pg, 2'b00, pg});
				rd(16'h8000, 1'b0);
				`CHK("window class", (s == 3) || k == 1, wi_s)
				`CHK("window xcs", (s == 3) || k == 1, xcs_s)
				`CHK("window xa", pg, xa_s)
			end
		end
		mode <= 2'h2;
		rd(16'h0032, 1'b0);
		`CHK("portk ext", 6'h20, sel_s)
		rd(16'hc000, 1'b0);
		`CHK("ecs", 2'b01, {ecs_s, xcs_s})
		mode <= 2'h3;
		rd(16'h000c, 1'b0);
		`CHK("periph reg", 1'b0, sel_s[1])
		mode <= 2'h0;
		call_page <= 6'h3a;
		call_target <= 16'h9000;
		ret_a <= 16'hc123;
		call_req <= 1'b1;
		@(posedge ref_clk);
		call_req <= 1'b0;
		#1;
		for (int i = 0; i < 20 && busy === 1'b1; i++) begin
			`CHK("irq block", 1'b1, irq_block)
			@(posedge ref_clk);
			#1;
		end
		`CHK("call page", 6'h3a, bif.page_value)
		`CHK("call pc", 16'h9000, pc_out)
		rtc_req <= 1'b1;
		@(posedge ref_clk);
		rtc_req <= 1'b0;
		#1;
		for (int i = 0; i < 20 && busy === 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK("rtc page", src[2][5:0], bif.page_value)
		`CHK("rtc pc", src[2], pc_out)
		end_of_test();
	end
endmodule
`default_nettype wire
